/* rtl/sra_defs.svh */
// Constants for the short reset entry arbiter: offsets, fields, reset values, timers.
// Assumes a 20 MHz system clock and a one millisecond tick derived from it.
// Function
// - Bus member: reset seen outside receive state, or without base prefix, counts as long.
// - Bus member seeing reset on a new port after debounce performs a long reset.
// - Isolated node, reset on new port inside 682 ms window: short reset.
// - Won short request in transmit: signal start, initiated and short set.
// - Bus member, known port outside receive, or new port after debounce: long, not initiated.
// - Long command, state timeout, parent loss, isolated node await expiry: initiated long reset.
// - Software command and, on a bus member, child change raise the same short request.
// - Short request only where fair request allowed, never in isochronous mode.
// - Short request beats a pending fair request.
// - Short request survives lost arbitration; fair request drops on win or loss.
// - Short request ignores the fairness enable bit.
// - Root serves cycle master first; non-root serves short request first.
// - Short request clears only on entering reset start.
// - Short request unwon for 341 ms falls back to a long reset.
// - Both software reset command bits clear on entering reset start.
// - Short command outside arbitration waits until arbitration phase is reached.
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH

`define SRA_CLK_HZ 20000000
`define SRA_MS_CYCLES (`SRA_CLK_HZ / 1000)
`define SRA_DEB_MS 9'd85
`define SRA_CIP_MS 9'd341
`define SRA_ABR_MS 9'd341
`define SRA_SRT_MS 9'd341

`define SRA_OFS_CTRL 4'h0
`define SRA_OFS_STATUS 4'h1
`define SRA_OFS_TIMER 4'h2

`define SRA_CTRL_LONG 0
`define SRA_CTRL_SHORT 1
`define SRA_CTRL_ARBEN 2
`define SRA_CTRL_RESET 3'h4

`endif

/* rtl/sra_pkg.sv */
// Types shared by the short reset entry arbiter modules.
// Assumes nothing beyond a SystemVerilog tool.
package sra_pkg;
    typedef enum logic [2:0] {ARB_OTHER, ARB_IDLE, ARB_REQUEST, ARB_RECEIVE, ARB_TRANSMIT} sra_arb_t;
    typedef enum logic [1:0] {REQ_NONE, REQ_FAIR, REQ_SHORT, REQ_CYCLE} sra_req_t;
    typedef enum logic [2:0] {PATH_NONE, PATH_RCV_SHORT, PATH_ISO_SHORT, PATH_LOCAL_SHORT,
        PATH_RCV_LONG, PATH_LOCAL_LONG, PATH_SHORT_TMO} sra_path_t;
endpackage : sra_pkg

/* rtl/sra_tick_if.sv */
// Carrier for the millisecond enable between divider and arbiter.
// Assumes both ends run on sys_clk_i.
`timescale 1ns/1ps
interface sra_tick_if;
    logic ms_tick;
    modport src (output ms_tick);
    modport dst (input ms_tick);
endinterface : sra_tick_if

/* rtl/sra_ms_tick.sv */
// Divider giving a one-cycle enable every millisecond.
// Assumes a single system clock and synchronous reset.
`timescale 1ns/1ps
`include "sra_defs.svh"
module sra_ms_tick #(
    parameter int MS_CYCLES = `SRA_MS_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    sra_tick_if.src tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic pulse;
    } sra_div_t;
    sra_div_t s;
    sra_div_t next_s;

    // Count down; pulse on wrap
    always_comb begin
        next_s = s;
        next_s.pulse = 1'b0;
        if (s.cnt == 32'h0000_0000) begin
            next_s.cnt = 32'(MS_CYCLES - 1);
            next_s.pulse = 1'b1;
        end else begin
            next_s.cnt = s.cnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick.ms_tick = s.pulse;
endmodule : sra_ms_tick

/* rtl/sra_sync.sv */
// Two-flop synchroniser for pin-level inputs, one stage pair per bit.
// Assumes inputs are slow levels from outside the clock domain.
`timescale 1ns/1ps
module sra_sync #(
    parameter int W = 5
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sra_sy_t;
    sra_sy_t s;
    sra_sy_t next_s;

    // First stage feeds only the second
    always_comb begin
        next_s.meta = raw_i;
        next_s.stable = s.meta;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    genvar i;
    for (i = 0; i < W; i++) begin : g_bit
        assign sync_o[i] = s.stable[i];
    end
endmodule : sra_sync

/* rtl/sra_arbiter.sv */
// Reset-start entry classifier and short reset request arbiter, with AHB-Lite registers.
// Assumes the arbitration state machine supplies its state and win/loss pulses on sys_clk_i,
// and that port detectors and connect status arrive asynchronously from the cable side.
`timescale 1ns/1ps
`include "sra_defs.svh"
module sra_arbiter #(
    parameter int MS_CYCLES = `SRA_MS_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Cable side, asynchronous
    input wire logic reset_seen_on_known_port_i,
    input wire logic reset_seen_on_new_port_i,
    input wire logic new_port_connect_i,
    input wire logic child_link_change_flag_i,
    input wire logic parent_disconnect_i,
    // Arbitration machine, same clock
    input wire logic bus_member_node_i,
    input sra_pkg::sra_arb_t arb_state_i,
    input wire logic base_prefix_i,
    input wire logic arb_state_timeout_i,
    input wire logic fair_window_i,
    input wire logic isoch_mode_i,
    input wire logic fair_req_i,
    input wire logic cycle_master_req_i,
    input wire logic is_root_i,
    input wire logic arb_won_i,
    input wire logic arb_lost_i,
    // Toward the link and arbitration machine
    output logic phy_state_indication_o,
    output logic initiated_reset_o,
    output logic go_short_o,
    output logic bus_request_o,
    output sra_pkg::sra_req_t request_kind_o
);
    typedef struct packed {
        logic sw_long;
        logic sw_short;
        logic arb_en;
        logic short_pend;
        logic short_won;
        logic fair_pend;
        logic [8:0] short_ms;
        logic [8:0] db_ms;
        logic db_done;
        logic [8:0] cip_ms;
        logic [8:0] abr_ms;
        logic [4:0] prev;
        logic start;
        logic initiated;
        logic go_short;
        sra_pkg::sra_path_t entry;
        sra_pkg::sra_req_t grant;
        logic dph_wr;
        logic [3:0] dph_idx;
        logic [31:0] rdata;
    } sra_state_t;

    sra_state_t s;
    sra_state_t next_s;
    logic [4:0] pins;
    logic known_rst;
    logic new_rst;
    logic new_conn;
    logic child_chg;
    logic parent_loss;
    logic ms_tick;
    logic addr_ok;
    logic wr_ctrl;
    logic allowed;
    logic sh_cand;
    logic window;
    logic abr_expire;
    logic short_tmo;

    sra_tick_if tick_bus ();

    sra_ms_tick #(.MS_CYCLES(MS_CYCLES)) u_tick (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .tick(tick_bus.src)
    );

    sra_sync #(.W(5)) u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .raw_i({parent_disconnect_i, child_link_change_flag_i, new_port_connect_i,
                reset_seen_on_new_port_i, reset_seen_on_known_port_i}),
        .sync_o(pins)
    );

    // Edges of synchronised levels; detectors may hold a level for a long time
    assign ms_tick = tick_bus.ms_tick;
    assign known_rst = pins[0] & ~s.prev[0];
    assign new_rst = pins[1] & ~s.prev[1];
    assign new_conn = pins[2] & ~s.prev[2];
    assign child_chg = pins[3] & ~s.prev[3];
    assign parent_loss = pins[4] & ~s.prev[4];

    // Bus decode: word aligned, zero wait state
    assign addr_ok = hsel_i & htrans_i[1] & hready_i;
    assign wr_ctrl = s.dph_wr & (s.dph_idx == `SRA_OFS_CTRL);
    assign allowed = fair_window_i & ~isoch_mode_i;
    assign sh_cand = s.short_pend & allowed & ~s.short_won;
    assign window = (s.cip_ms != 9'h000) | (s.abr_ms != 9'h000);
    assign abr_expire = ms_tick & (s.abr_ms == 9'h001);
    assign short_tmo = s.short_pend & (s.short_ms == `SRA_SRT_MS);

    always_comb begin
        next_s = s;
        next_s.prev = pins;
        next_s.start = 1'b0;
        next_s.rdata = 32'h0000_0000;
        next_s.dph_wr = addr_ok & hwrite_i;
        next_s.dph_idx = haddr_i[5:2];

        // Register read data staged in the address phase
        if (addr_ok & ~hwrite_i) begin
            case (haddr_i[5:2])
                `SRA_OFS_CTRL: next_s.rdata = {29'h0000_0000, s.arb_en, s.sw_short, s.sw_long};
                `SRA_OFS_STATUS: next_s.rdata = {23'h00_0000, s.db_done, window, s.entry,
                    s.fair_pend, s.short_pend, s.go_short, s.initiated};
                `SRA_OFS_TIMER: next_s.rdata = {23'h00_0000, s.short_ms};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // New connection timers: debounce alongside connect wait followed by await reset
        if (new_conn) begin
            next_s.db_ms = `SRA_DEB_MS;
            next_s.db_done = 1'b0;
            next_s.cip_ms = `SRA_CIP_MS;
            next_s.abr_ms = 9'h000;
        end else if (ms_tick) begin
            if (s.db_ms != 9'h000) begin
                next_s.db_ms = s.db_ms - 9'h001;
                next_s.db_done = (s.db_ms == 9'h001);
            end
            if (s.cip_ms != 9'h000) begin
                next_s.cip_ms = s.cip_ms - 9'h001;
                if (s.cip_ms == 9'h001) begin
                    next_s.abr_ms = `SRA_ABR_MS;
                end
            end else if (s.abr_ms != 9'h000) begin
                next_s.abr_ms = s.abr_ms - 9'h001;
            end
        end

        // age of the pending short request
        if (s.short_pend & ms_tick & (s.short_ms != `SRA_SRT_MS)) begin
            next_s.short_ms = s.short_ms + 9'h001;
        end

        // fair request dropped on win or loss, new request wins
        if (arb_won_i | arb_lost_i) begin
            next_s.fair_pend = 1'b0;
        end
        if (fair_req_i) begin
            next_s.fair_pend = 1'b1;
        end

        // only a win ends the short request's contention
        if (arb_won_i & (s.grant == sra_pkg::REQ_SHORT)) begin
            next_s.short_won = 1'b1;
        end

        // Request selection, registered toward the arbitration machine
        next_s.grant = sra_pkg::REQ_NONE;
        if (is_root_i & cycle_master_req_i) begin
            // root lets a cycle start go first
            next_s.grant = sra_pkg::REQ_CYCLE;
        end else if (sh_cand) begin
            // short ahead of fair, no enable bit
            next_s.grant = sra_pkg::REQ_SHORT;
        end else if (cycle_master_req_i) begin
            next_s.grant = sra_pkg::REQ_CYCLE;
        end else if (s.fair_pend & s.arb_en & allowed) begin
            next_s.grant = sra_pkg::REQ_FAIR;
        end

        // Entry to reset start; local long causes outrank received signals
        // locally initiated long reset
        if (s.sw_long | arb_state_timeout_i | parent_loss | (~bus_member_node_i & abr_expire)) begin
            next_s.start = 1'b1;
            next_s.initiated = 1'b1;
            next_s.go_short = 1'b0;
            next_s.entry = sra_pkg::PATH_LOCAL_LONG;
        end else if (short_tmo) begin
            next_s.start = 1'b1;
            next_s.initiated = 1'b1;
            next_s.go_short = 1'b0;
            next_s.entry = sra_pkg::PATH_SHORT_TMO;
        end else if (~bus_member_node_i & new_rst & window) begin
            // isolated node follows the neighbour's short reset
            next_s.start = 1'b1;
            next_s.initiated = 1'b0;
            next_s.go_short = 1'b1;
            next_s.entry = sra_pkg::PATH_ISO_SHORT;
        end else if (bus_member_node_i & known_rst & (arb_state_i == sra_pkg::ARB_RECEIVE) & base_prefix_i
                & ~(new_rst & s.db_done)) begin
            // short reset from an arbitrating neighbour, unless a new port saw one too
            next_s.start = 1'b1;
            next_s.initiated = 1'b0;
            next_s.go_short = 1'b1;
            next_s.entry = sra_pkg::PATH_RCV_SHORT;
        end else if (bus_member_node_i & (known_rst | (new_rst & s.db_done))) begin
            next_s.start = 1'b1;
            next_s.initiated = 1'b0;
            next_s.go_short = 1'b0;
            next_s.entry = sra_pkg::PATH_RCV_LONG;
        end else if (s.short_won & (arb_state_i == sra_pkg::ARB_TRANSMIT)) begin
            // won arbitration, now transmitting the short reset
            next_s.start = 1'b1;
            next_s.initiated = 1'b1;
            next_s.go_short = 1'b1;
            next_s.entry = sra_pkg::PATH_LOCAL_SHORT;
        end

        // entering reset start clears the short request and commands; fair request kept
        if (next_s.start) begin
            next_s.short_pend = 1'b0;
            next_s.short_won = 1'b0;
            next_s.short_ms = 9'h000;
            next_s.sw_long = 1'b0;
            next_s.sw_short = 1'b0;
        end

        // a reset ends the await, so no stray long reset follows; a fresh connect restarts it
        if (next_s.start & ~new_conn) begin
            next_s.cip_ms = 9'h000;
            next_s.abr_ms = 9'h000;
        end

        // command and, on a bus member, child change raise one request; a set beats the clear
        if (bus_member_node_i & child_chg) begin
            next_s.short_pend = 1'b1;
        end
        if (wr_ctrl) begin
            next_s.arb_en = hwdata_i[`SRA_CTRL_ARBEN];
            if (hwdata_i[`SRA_CTRL_LONG]) begin
                next_s.sw_long = 1'b1;
            end
            if (hwdata_i[`SRA_CTRL_SHORT]) begin
                next_s.sw_short = 1'b1;
                next_s.short_pend = 1'b1;
            end
        end
    end

    // Single state register
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s <= '0;
            s.arb_en <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state; bus never stalls or errors
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = s.rdata;
    assign phy_state_indication_o = s.start;
    assign initiated_reset_o = s.initiated;
    assign go_short_o = s.go_short;
    assign bus_request_o = (s.grant != sra_pkg::REQ_NONE);
    assign request_kind_o = s.grant;

    // Checks next to the logic
    a_short_clear_only: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $fell(s.short_pend) |-> s.start)
        else $error("short request cleared outside reset start");
    a_recv_short: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_RCV_SHORT |-> $past(arb_state_i) == sra_pkg::ARB_RECEIVE
        && go_short_o && !initiated_reset_o)
        else $error("received short reset outside receive state");
    a_recv_long: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_RCV_LONG |-> !initiated_reset_o && !go_short_o)
        else $error("received long reset has wrong flags");
    a_new_port_long: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(bus_member_node_i && new_rst && s.db_done && !s.sw_long && !short_tmo && !parent_loss
        && !arb_state_timeout_i) |-> s.start && !go_short_o)
        else $error("new port reset on bus member not long");
    a_iso_short: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_ISO_SHORT |-> go_short_o && !initiated_reset_o
        && !$past(bus_member_node_i))
        else $error("isolated node short reset wrong");
    a_local_short: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_LOCAL_SHORT |-> initiated_reset_o && go_short_o
        && $past(arb_state_i) == sra_pkg::ARB_TRANSMIT)
        else $error("local short reset wrong");
    a_local_long: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(arb_state_timeout_i) |-> s.start && initiated_reset_o && !go_short_o)
        else $error("state timeout did not force long reset");
    a_cmd_autoclr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && !$past(wr_ctrl) |-> !s.sw_long && !s.sw_short)
        else $error("command bits survived reset start");
    a_short_over_fair: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        request_kind_o == sra_pkg::REQ_FAIR |-> !$past(sh_cand))
        else $error("fair served before short");
    a_no_isoch_req: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        request_kind_o == sra_pkg::REQ_SHORT |-> $past(fair_window_i && !isoch_mode_i))
        else $error("short request outside fair window");
    a_root_cycle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(is_root_i && cycle_master_req_i) |-> request_kind_o == sra_pkg::REQ_CYCLE)
        else $error("root did not serve cycle master first");
    a_fair_drop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(arb_lost_i && !fair_req_i) |-> !s.fair_pend)
        else $error("fair request survived loss");
    a_short_tmo: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.short_ms == `SRA_SRT_MS && s.short_pend |=> s.start && !go_short_o)
        else $error("short timeout did not force long reset");
    a_outside_rcv_long: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(bus_member_node_i && known_rst && arb_state_i != sra_pkg::ARB_RECEIVE) |-> s.start && !go_short_o)
        else $error("reset outside receive state not long");
    a_iso_expire_long: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(!bus_member_node_i && abr_expire) |-> s.start && initiated_reset_o && !go_short_o)
        else $error("isolated node await expiry did not force long reset");

    c_local_short: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_LOCAL_SHORT);
    c_recv_short: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_RCV_SHORT);
    c_lost_then_won: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.short_pend && arb_lost_i ##[1:50] s.short_pend && arb_won_i);
    c_iso_short: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_ISO_SHORT);
    c_iso_expire: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s.start && s.entry == sra_pkg::PATH_LOCAL_LONG && !bus_member_node_i);
endmodule : sra_arbiter

/* test/sra_peer_model.sv */
// Neighbour PHY on a known cable port: sends a reset signal on command.
// Assumes bench commands on sys_clk_i; the arbiter treats the line as async.
`timescale 1ns/1ps
module sra_peer_model #(
    parameter int HOLD = 12
) (
    input wire logic sys_clk_i,
    input wire logic send_i,
    input wire logic short_i,
    output logic reset_seen_on_known_port_o,
    output logic base_prefix_o
);
    int cnt = 0;
    initial reset_seen_on_known_port_o = 1'b0;
    initial base_prefix_o = 1'b0;
    // prefix first, then reset
    // Prefix level is set a cycle before the reset line rises, as a real sender would
    always @(posedge sys_clk_i) begin
        if (send_i) begin
            base_prefix_o <= short_i;
            cnt <= HOLD;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        reset_seen_on_known_port_o <= (cnt > 1);
    end
endmodule : sra_peer_model

/* test/short_reset_entry_arbiter_tb_top.sv */
// Self-checking bench for the reset entry arbiter with a request model.
// Assumes a short millisecond divider so timeouts fit in a few thousand cycles.
`timescale 1ns/1ps
module short_reset_entry_arbiter_tb_top;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic child = 1'b0, parent = 1'b0, tmo = 1'b0, win_open = 1'b0, iso = 1'b0, fair = 1'b0;
    logic cyc = 1'b0, root = 1'b0, won = 1'b0, lost = 1'b0, send = 1'b0, shrt = 1'b0;
    logic known, prefix, ind, init, gos, breq;
    logic conn = 1'b0, newp = 1'b0, bm = 1'b1;
    sra_pkg::sra_arb_t st = sra_pkg::ARB_OTHER;
    sra_pkg::sra_req_t kind;
    int mismatches = 0, compares = 0, sp = 0, fp = 0, arben = 1;
    logic [15:0] lfsr = 16'h0053;
    always #25 sys_clk_i = ~sys_clk_i;
    sra_peer_model i_peer (.sys_clk_i(sys_clk_i), .send_i(send), .short_i(shrt),
        .reset_seen_on_known_port_o(known), .base_prefix_o(prefix));
    sra_arbiter #(.MS_CYCLES(4)) i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .reset_seen_on_known_port_i(known), .reset_seen_on_new_port_i(newp), .new_port_connect_i(conn),
        .child_link_change_flag_i(child), .parent_disconnect_i(parent), .bus_member_node_i(bm),
        .arb_state_i(st), .base_prefix_i(prefix), .arb_state_timeout_i(tmo), .fair_window_i(win_open),
        .isoch_mode_i(iso), .fair_req_i(fair), .cycle_master_req_i(cyc), .is_root_i(root),
        .arb_won_i(won), .arb_lost_i(lost), .phy_state_indication_o(ind), .initiated_reset_o(init),
        .go_short_o(gos), .bus_request_o(breq), .request_kind_o(kind));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nxt
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Single AHB-Lite transfer; holds each phase until hready is seen high
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge sys_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    task automatic cmp_reg(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000, rd);
        cmp("register", exp, rd);
        cmp("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask : cmp_reg
    // Random upper bits ride along; only the low three bits mean anything
    task automatic wr_ctrl(input logic [2:0] bits);
        lfsr = nxt(lfsr);
        ahb(1'b1, 32'h0000_0000, {lfsr, 13'h0000, bits}, rd);
        if (bits[1]) sp = 1;
        arben = bits[2];
    endtask : wr_ctrl
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : settle
    // One-cycle strobe; the request model follows the same event
    task automatic pulse(input int k);
        @(posedge sys_clk_i);
        case (k)
            0: won <= 1'b1;
            1: lost <= 1'b1;
            2: fair <= 1'b1;
            3: tmo <= 1'b1;
            4: parent <= 1'b1;
            6: conn <= 1'b1;
            7: newp <= 1'b1;
            default: child <= 1'b1;
        endcase
        @(posedge sys_clk_i);
        {won, lost, fair, tmo, parent, child, conn, newp} <= 8'h00;
        if (k == 0 && sp == 1) sp = 2;
        if (k < 2) fp = 0;
        if (k == 2) fp = 1;
        if (k == 5) sp = 1;
    endtask : pulse
    // Grant expected from pending requests, window, mode and root priority
    task automatic cmp_req;
        sra_pkg::sra_req_t e;
        if (root && cyc) e = sra_pkg::REQ_CYCLE;
        else if (win_open && !iso && sp == 1) e = sra_pkg::REQ_SHORT;
        else if (cyc) e = sra_pkg::REQ_CYCLE;
        else if (win_open && !iso && fp == 1 && arben == 1) e = sra_pkg::REQ_FAIR;
        else e = sra_pkg::REQ_NONE;
        cmp("request_kind", e, kind);
        cmp("bus_request", e != sra_pkg::REQ_NONE, breq);
    endtask : cmp_req
    // Waits for the reset start pulse, checks flags and one-cycle width
    task automatic cmp_entry(input logic ei, input logic es);
        int n;
        n = 0;
        // Let this edge's updates land, so a pulse launched at it is not missed
        #1;
        while (ind !== 1'b1 && n < 3000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        cmp("reset_start", 1'b1, ind);
        cmp("initiated", ei, init);
        cmp("go_short", es, gos);
        settle(1);
        cmp("reset_start_width", 1'b0, ind);
        sp = 0;
    endtask : cmp_entry
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // Cuts a hang short after about 20000 cycles
    initial begin
        #1000000;
        mismatches++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        cmp_reg(32'h0000_0000, 32'h0000_0004);
        cmp_reg(32'h0000_003c, 32'h0000_0000);
        wr_ctrl(3'h6);
        settle(2);
        cmp_req();
        @(posedge sys_clk_i);
        st <= sra_pkg::ARB_REQUEST;
        win_open <= 1'b1;
        settle(2);
        cmp_req();
        pulse(2);
        settle(1);
        cmp_req();
        pulse(1);
        settle(1);
        cmp_req();
        iso <= 1'b1;
        settle(2);
        cmp_req();
        iso <= 1'b0;
        for (int r = 0; r < 2; r++) begin
            @(posedge sys_clk_i);
            cyc <= 1'b1;
            root <= r[0];
            settle(2);
            cmp_req();
        end
        cyc <= 1'b0;
        pulse(0);
        settle(1);
        cmp_req();
        st <= sra_pkg::ARB_TRANSMIT;
        cmp_entry(1'b1, 1'b1);
        st <= sra_pkg::ARB_REQUEST;
        cmp_reg(32'h0000_0000, 32'h0000_0004);
        wr_ctrl(3'h0);
        pulse(5);
        settle(5);
        cmp_req();
        pulse(2);
        settle(1);
        cmp_req();
        pulse(0);
        st <= sra_pkg::ARB_TRANSMIT;
        cmp_entry(1'b1, 1'b1);
        st <= sra_pkg::ARB_RECEIVE;
        send <= 1'b1;
        shrt <= 1'b1;
        @(posedge sys_clk_i);
        send <= 1'b0;
        cmp_entry(1'b0, 1'b1);
        st <= sra_pkg::ARB_REQUEST;
        settle(15);
        send <= 1'b1;
        shrt <= 1'b0;
        @(posedge sys_clk_i);
        send <= 1'b0;
        cmp_entry(1'b0, 1'b0);
        wr_ctrl(3'h5);
        cmp_entry(1'b1, 1'b0);
        cmp_reg(32'h0000_0000, 32'h0000_0004);
        for (int k = 3; k < 5; k++) begin
            pulse(k);
            cmp_entry(1'b1, 1'b0);
        end
        bm <= 1'b0;
        pulse(6);
        settle(20);
        pulse(7);
        cmp_entry(1'b0, 1'b1);
        pulse(6);
        cmp_entry(1'b1, 1'b0);
        bm <= 1'b1;
        pulse(6);
        settle(400);
        pulse(7);
        cmp_entry(1'b0, 1'b0);
        win_open <= 1'b0;
        wr_ctrl(3'h6);
        cmp_entry(1'b1, 1'b0);
        conclude();
    end
endmodule : short_reset_entry_arbiter_tb_top
